// file: psm_map.svh
// Register offsets, field positions, reset values and timing for the block.
// Function
// - Printer port ranges count as activity.
// - Only keyboard port reads count as activity.
// - External clock port accesses count as activity.
// - Both serial port ranges count as activity.
// - Floppy data and hard-disk ports count.
// - Video memory and programmable range count.
// - Per-state register drives the power pins.
// - Power registers reset to fixed values.
// - Polarity register inverts each pin bit.
// - LCD pins float after reset, others driven.
// - LCD sequencing waits for both enables.
// - State register reads and forces state.
// - LCD controller gets power on indication.
// - Low battery raises a maskable interrupt.
// - Clock full in ON, slowed when idle; divider codes 0 and 3 stop it.
// - SUSPEND stops clocks, floats pins, keeps refresh.
// - Interrupt or DMA only speeds the clock.
// - SLEEP behaves like DOZE with own pins; here lcd_power_on drops in SLEEP.
// - DOZE timer, divider register, NMI enable.
// - DOZE exits on activity or timer.
// - Three ways into SLEEP; the code has two, state write and the sleep timer in DOZE.
// - Writes locked until supply register read.
// - Writing 03H to state enters SUSPEND.
`ifndef PSM_MAP_SVH
`define PSM_MAP_SVH
`define PSM_IDX_STATE 8'hC0
`define PSM_IDX_SUPPLY 8'hC1
`define PSM_IDX_NMI_MASK 8'hC4
`define PSM_IDX_ON_PINS 8'hC6
`define PSM_IDX_DOZE_PINS 8'hC7
`define PSM_IDX_SLEEP_PINS 8'hC8
`define PSM_IDX_SUSPEND_PINS 8'hC9
`define PSM_IDX_POLARITY 8'hCA
`define PSM_IDX_DOZE_TIMER 8'hCC
`define PSM_IDX_SLEEP_TIMER 8'hCD
`define PSM_IDX_SUSPEND_TIMER 8'hCE
`define PSM_IDX_LCD_SEQ 8'hD4
`define PSM_IDX_RESUME 8'hDA
`define PSM_IDX_ACTIVITY 8'hDB
`define PSM_IDX_RANGE_LO 8'hE0
`define PSM_IDX_RANGE_HI 8'hE1
`define PSM_RST_ON_PINS 8'hFE
`define PSM_RST_DOZE_PINS 8'hFF
`define PSM_RST_SLEEP_PINS 8'h0C
`define PSM_RST_SUSPEND_PINS 8'h00
`define PSM_RST_POLARITY 8'h01
`define PSM_RST_NMI_MASK 8'hFF
`define PSM_BIT_LCD 0
`define PSM_BIT_SYS 2
`define PSM_BIT_CARD 3
`define PSM_BIT_RAM 7
`define PSM_MASK_LOWBAT 0
`define PSM_MASK_EXT 1
`define PSM_MASK_SLEEP 4
`define PSM_MASK_SUSPEND 5
`define PSM_STATE_OFF_BIT 2
`define PSM_DISPLAY_ON_BIT 3
`define PSM_PORT_KBD 16'h0060
`define PSM_PORT_RTC0 16'h0070
`define PSM_PORT_RTC1 16'h0071
`define PSM_PORT_FLOPPY 16'h03F5
`define PSM_PORT_MODE_A 16'h03D8
`define PSM_LPT1_LO 16'h0378
`define PSM_LPT1_HI 16'h037F
`define PSM_LPT2_LO 16'h0278
`define PSM_LPT2_HI 16'h027F
`define PSM_LPT3_LO 16'h03BC
`define PSM_LPT3_HI 16'h03BE
`define PSM_COM1_LO 16'h03F8
`define PSM_COM1_HI 16'h03FF
`define PSM_COM2_LO 16'h02F8
`define PSM_COM2_HI 16'h02FF
`define PSM_HDD_LO 16'h01F0
`define PSM_HDD_HI 16'h01F8
`define PSM_CLOCK_KHZ 50000
`define PSM_TICK_TIME_MS 1000
`define PSM_TICK_CYCLES (`PSM_TICK_TIME_MS * `PSM_CLOCK_KHZ)
`endif

// file: psm_pkg.sv
// Types shared by the power state manager.
package psm_pkg;
	typedef enum logic [2:0] {
		PSM_ON,
		PSM_DOZE,
		PSM_SLEEP,
		PSM_SUSPEND,
		PSM_OFF
	} psm_state_t;
	typedef enum logic [1:0] {
		PSM_CLK_FULL,
		PSM_CLK_DIV4,
		PSM_CLK_DIV8,
		PSM_CLK_STOP
	} psm_clock_t;
	typedef struct packed {
		logic strobe;
		logic write;
		logic external;
		logic [15:0] address;
		logic [7:0] data;
	} psm_io_t;
	typedef struct packed {
		logic lcd_power_pin;
		logic lcd_power_oe;
		logic lcd_bias_power_pin;
		logic lcd_bias_power_oe;
		logic system_power_pin;
		logic card_power_pin;
		logic ram_power_pin;
	} psm_pins_t;
endpackage

// file: psm_power_state_manager.sv
// Power state manager with activity monitor and Avalon-MM registers.
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
`include "psm_map.svh"
module psm_power_state_manager #(
	parameter int TICK_CYCLES = `PSM_TICK_CYCLES
) (
	// Clock, reset and enable.
	input wire logic clock,
	input wire logic reset,
	input wire logic clock_enable,
	// Avalon-MM slave.
	input wire logic [9:0] address,
	input wire logic [3:0] byteenable,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// CPU bus observation.
	input wire psm_pkg::psm_io_t io_bus,
	input wire logic video_access,
	input wire logic int_request,
	input wire logic dma_request,
	// Wake and status inputs.
	input wire logic wake_switch_input,
	input wire logic modem_ring_wake,
	input wire logic rtc_alarm,
	input wire logic low_battery,
	// Power pins and system controls.
	output psm_pkg::psm_pins_t power_pins,
	output psm_pkg::psm_clock_t cpu_clock_mode,
	output logic oscillator_enable,
	output logic io_pins_hiz,
	output logic memory_hiz,
	output logic refresh_active,
	output logic lcd_power_on,
	output logic low_battery_irq,
	output logic nmi
);
	psm_pkg::psm_state_t state;
	logic [7:0] on_state_power_pins;
	logic [7:0] doze_state_power_pins;
	logic [7:0] sleep_state_power_pins;
	logic [7:0] suspend_state_power_pins;
	logic [7:0] polarity;
	logic [7:0] nmi_mask;
	logic [7:0] doze_timer;
	logic [7:0] sleep_timer;
	logic [7:0] suspend_timer;
	logic [7:0] resume_divider;
	logic [6:0] activity_status;
	logic [7:0] range_lo;
	logic [7:0] range_hi;
	logic lcd_sequence_enable;
	logic display_on_bit;
	logic lcd_armed;
	logic unlocked;
	logic ext_nmi_enable;
	logic resume_flag;
	logic [2:0] nmi_cause;
	logic [31:0] tick_count;
	logic tick;
	logic tick_seen;
	logic [7:0] idle_count;
	logic ext_last;
	logic [7:0] index;
	logic access;
	logic reg_write;
	logic reg_read;
	logic [6:0] act_hit;
	logic any_activity;
	logic wake;
	logic ext_rise;
	logic doze_expire;
	logic sleep_expire;
	logic suspend_expire;
	logic timer_move;
	logic [7:0] state_code;
	logic [7:0] active_pins;
	logic [7:0] next_read;
	logic slow_doze;
	psm_pkg::psm_clock_t next_clock;

	function automatic logic in_range(input logic [15:0] a,
		input logic [15:0] lo, input logic [15:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	function automatic psm_pkg::psm_clock_t divider(input logic [1:0] f);
		case (f)
			2'h1: divider = psm_pkg::PSM_CLK_DIV4;
			2'h2: divider = psm_pkg::PSM_CLK_DIV8;
			default: divider = psm_pkg::PSM_CLK_STOP;
		endcase
	endfunction

	// Bus decode: a request is taken on the cycle waitrequest is low.
	assign index = address[9:2];
	assign access = (read || write) && !waitrequest;
	assign reg_write = access && write && byteenable[0] && unlocked;
	assign reg_read = access && read;

	// Activity decode from the observed I/O bus and the video access input.
	always_comb begin
		act_hit = 7'h00;
		if (io_bus.strobe) begin
			act_hit[0] = in_range(io_bus.address, `PSM_LPT1_LO, `PSM_LPT1_HI)
				|| in_range(io_bus.address, `PSM_LPT2_LO, `PSM_LPT2_HI)
				|| in_range(io_bus.address, `PSM_LPT3_LO, `PSM_LPT3_HI);
			act_hit[1] = !io_bus.write
				&& io_bus.address == `PSM_PORT_KBD;
			act_hit[2] = io_bus.external
				&& (io_bus.address == `PSM_PORT_RTC0
				|| io_bus.address == `PSM_PORT_RTC1);
			act_hit[3] = in_range(io_bus.address, `PSM_COM1_LO, `PSM_COM1_HI)
				|| in_range(io_bus.address, `PSM_COM2_LO, `PSM_COM2_HI);
			act_hit[4] = io_bus.address == `PSM_PORT_FLOPPY
				|| in_range(io_bus.address, `PSM_HDD_LO, `PSM_HDD_HI);
			act_hit[6] = io_bus.address[15:3] == {range_hi, range_lo[7:3]};
		end
		act_hit[5] = video_access;
	end

	// Activity hits are ignored while suspended or off.
	assign any_activity = (|act_hit) && state != psm_pkg::PSM_SUSPEND
		&& state != psm_pkg::PSM_OFF;
	assign wake = wake_switch_input || modem_ring_wake || rtc_alarm;
	assign ext_rise = wake_switch_input && !ext_last;
	assign doze_expire = tick_seen && doze_timer != 8'h00
		&& idle_count == doze_timer;
	assign sleep_expire = tick_seen && sleep_timer != 8'h00
		&& idle_count == sleep_timer;
	assign suspend_expire = tick_seen && suspend_timer != 8'h00
		&& idle_count == suspend_timer;
	assign slow_doze = resume_divider[1:0] != 2'h0;
	assign timer_move = state == psm_pkg::PSM_ON && doze_expire
		|| state == psm_pkg::PSM_DOZE && sleep_expire
		|| state == psm_pkg::PSM_SLEEP && suspend_expire;

	// Timebase and idle counter in ticks, cleared by activity, a timer expiry or a state write.
	always_ff @(posedge clock) begin
		if (reset) begin
			tick_count <= 32'h00000000;
			tick <= 1'b0;
			tick_seen <= 1'b0;
			idle_count <= 8'h00;
			ext_last <= 1'b0;
		end else if (clock_enable) begin
			tick <= tick_count == 32'(TICK_CYCLES - 1);
			tick_count <= (tick_count == 32'(TICK_CYCLES - 1)) ? 32'h00000000
				: tick_count + 32'h00000001;
			tick_seen <= tick;
			ext_last <= wake_switch_input;
			if (any_activity || timer_move
				|| reg_write && index == `PSM_IDX_STATE)
				idle_count <= 8'h00;
			else if (tick && idle_count != 8'hFF)
				idle_count <= idle_count + 8'h01;
		end
	end

	// Power state machine.
	always_ff @(posedge clock) begin
		if (reset) begin
			state <= psm_pkg::PSM_ON;
		end else if (clock_enable) begin
			case (state)
				psm_pkg::PSM_SUSPEND, psm_pkg::PSM_OFF: begin
					if (wake)
						state <= psm_pkg::PSM_ON;
				end
				default: begin
					if (reg_write && index == `PSM_IDX_STATE) begin
						if (writedata[`PSM_STATE_OFF_BIT])
							state <= psm_pkg::PSM_OFF;
						else
							state <= psm_pkg::psm_state_t'({1'b0,
								writedata[1:0]});
					end else if (state == psm_pkg::PSM_ON) begin
						if (doze_expire)
							state <= psm_pkg::PSM_DOZE;
					end else if (any_activity) begin
						state <= psm_pkg::PSM_ON;
					end else if (state == psm_pkg::PSM_DOZE && sleep_expire
						&& nmi_mask[`PSM_MASK_SLEEP] && slow_doze) begin
						state <= psm_pkg::PSM_SLEEP;
					end
				end
			endcase
		end
	end

	// Software registers.
	always_ff @(posedge clock) begin
		if (reset) begin
			on_state_power_pins <= `PSM_RST_ON_PINS;
			doze_state_power_pins <= `PSM_RST_DOZE_PINS;
			sleep_state_power_pins <= `PSM_RST_SLEEP_PINS;
			suspend_state_power_pins <= `PSM_RST_SUSPEND_PINS;
			polarity <= `PSM_RST_POLARITY;
			nmi_mask <= `PSM_RST_NMI_MASK;
			doze_timer <= 8'h00;
			sleep_timer <= 8'h00;
			suspend_timer <= 8'h00;
			resume_divider <= 8'h00;
			range_lo <= 8'h00;
			range_hi <= 8'h00;
			lcd_sequence_enable <= 1'b0;
			ext_nmi_enable <= 1'b0;
		end else if (clock_enable && reg_write) begin
			case (index)
				`PSM_IDX_ON_PINS: on_state_power_pins <= writedata[7:0];
				`PSM_IDX_DOZE_PINS: doze_state_power_pins <= writedata[7:0];
				`PSM_IDX_SLEEP_PINS: sleep_state_power_pins <= writedata[7:0];
				`PSM_IDX_SUSPEND_PINS: suspend_state_power_pins <= writedata[7:0];
				`PSM_IDX_POLARITY: polarity <= writedata[7:0];
				`PSM_IDX_NMI_MASK: nmi_mask <= writedata[7:0];
				`PSM_IDX_DOZE_TIMER: doze_timer <= writedata[7:0];
				`PSM_IDX_SLEEP_TIMER: sleep_timer <= writedata[7:0];
				`PSM_IDX_SUSPEND_TIMER: suspend_timer <= writedata[7:0];
				`PSM_IDX_LCD_SEQ: lcd_sequence_enable <= writedata[0];
				`PSM_IDX_RESUME: begin
					resume_divider <= writedata[7:0];
					ext_nmi_enable <= 1'b1;
				end
				`PSM_IDX_RANGE_LO: range_lo <= writedata[7:0];
				`PSM_IDX_RANGE_HI: range_hi <= writedata[7:0];
				default: ;
			endcase
		end
	end

	// Write protection, resume flag and display enable snoop.
	always_ff @(posedge clock) begin
		if (reset) begin
			unlocked <= 1'b0;
			resume_flag <= 1'b0;
			display_on_bit <= 1'b0;
			lcd_armed <= 1'b0;
		end else if (clock_enable) begin
			if ((state == psm_pkg::PSM_SUSPEND || state == psm_pkg::PSM_OFF)
				&& wake)
				unlocked <= 1'b0;
			else if (reg_read && index == `PSM_IDX_SUPPLY)
				unlocked <= 1'b1;
			if ((state == psm_pkg::PSM_SUSPEND || state == psm_pkg::PSM_OFF)
				&& wake)
				resume_flag <= 1'b1;
			else if (reg_read && index == `PSM_IDX_STATE)
				resume_flag <= 1'b0;
			if (io_bus.strobe && io_bus.write
				&& io_bus.address == `PSM_PORT_MODE_A)
				display_on_bit <= io_bus.data[`PSM_DISPLAY_ON_BIT];
			if (lcd_sequence_enable && display_on_bit)
				lcd_armed <= 1'b1;
		end
	end

	// Sticky activity and NMI causes; a new event wins over the read clear.
	always_ff @(posedge clock) begin
		if (reset) begin
			activity_status <= 7'h00;
			nmi_cause <= 3'h0;
		end else if (clock_enable) begin
			activity_status <= (reg_read && index == `PSM_IDX_ACTIVITY
				? 7'h00 : activity_status)
				| (any_activity ? act_hit : 7'h00);
			nmi_cause <= (reg_read && index == `PSM_IDX_NMI_MASK
				? 3'h0 : nmi_cause)
				| {ext_rise && ext_nmi_enable && !nmi_mask[`PSM_MASK_EXT]
				&& state != psm_pkg::PSM_SUSPEND && state != psm_pkg::PSM_OFF,
				state == psm_pkg::PSM_SLEEP && suspend_expire
				&& !nmi_mask[`PSM_MASK_SUSPEND],
				state == psm_pkg::PSM_DOZE && sleep_expire
				&& !nmi_mask[`PSM_MASK_SLEEP]};
		end
	end

	// Pin and clock outputs, each from a flip-flop.
	always_comb begin
		case (state)
			psm_pkg::PSM_ON: active_pins = on_state_power_pins;
			psm_pkg::PSM_DOZE: active_pins = doze_state_power_pins;
			psm_pkg::PSM_SLEEP: active_pins = sleep_state_power_pins;
			default: active_pins = suspend_state_power_pins;
		endcase
		active_pins = active_pins ^ polarity;
		case (state)
			psm_pkg::PSM_ON: next_clock = psm_pkg::PSM_CLK_FULL;
			psm_pkg::PSM_DOZE: next_clock = divider(resume_divider[1:0]);
			psm_pkg::PSM_SLEEP: next_clock = divider(resume_divider[3:2]);
			default: next_clock = psm_pkg::PSM_CLK_STOP;
		endcase
		if ((state == psm_pkg::PSM_DOZE || state == psm_pkg::PSM_SLEEP)
			&& (int_request || dma_request))
			next_clock = psm_pkg::PSM_CLK_FULL;
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			power_pins <= '0;
			cpu_clock_mode <= psm_pkg::PSM_CLK_FULL;
			oscillator_enable <= 1'b1;
			io_pins_hiz <= 1'b0;
			memory_hiz <= 1'b0;
			refresh_active <= 1'b0;
			lcd_power_on <= 1'b0;
			low_battery_irq <= 1'b0;
			nmi <= 1'b0;
		end else if (clock_enable) begin
			power_pins.lcd_power_pin <= active_pins[`PSM_BIT_LCD];
			power_pins.lcd_bias_power_pin <= active_pins[`PSM_BIT_LCD];
			power_pins.lcd_power_oe <= lcd_armed;
			power_pins.lcd_bias_power_oe <= lcd_armed;
			power_pins.system_power_pin <= active_pins[`PSM_BIT_SYS];
			power_pins.card_power_pin <= active_pins[`PSM_BIT_CARD];
			power_pins.ram_power_pin <= active_pins[`PSM_BIT_RAM];
			cpu_clock_mode <= next_clock;
			oscillator_enable <= state != psm_pkg::PSM_SUSPEND
				&& state != psm_pkg::PSM_OFF;
			io_pins_hiz <= state == psm_pkg::PSM_SUSPEND
				|| state == psm_pkg::PSM_OFF;
			memory_hiz <= state == psm_pkg::PSM_OFF;
			refresh_active <= state == psm_pkg::PSM_SUSPEND;
			lcd_power_on <= lcd_armed && (state == psm_pkg::PSM_ON
				|| state == psm_pkg::PSM_DOZE);
			low_battery_irq <= low_battery
				&& !nmi_mask[`PSM_MASK_LOWBAT];
			nmi <= |nmi_cause;
		end
	end

	// Read data mux.
	always_comb begin
		case (state)
			psm_pkg::PSM_ON: state_code = 8'h00;
			psm_pkg::PSM_DOZE: state_code = 8'h01;
			psm_pkg::PSM_SLEEP: state_code = 8'h02;
			psm_pkg::PSM_SUSPEND: state_code = 8'h03;
			default: state_code = 8'h07;
		endcase
		case (index)
			`PSM_IDX_STATE: next_read = {resume_flag, nmi_cause[2],
				nmi_cause[1], nmi_cause[0], 1'b0, state_code[2:0]};
			`PSM_IDX_SUPPLY: next_read = {7'h00, low_battery};
			`PSM_IDX_NMI_MASK: next_read = nmi_mask;
			`PSM_IDX_ON_PINS: next_read = on_state_power_pins;
			`PSM_IDX_DOZE_PINS: next_read = doze_state_power_pins;
			`PSM_IDX_SLEEP_PINS: next_read = sleep_state_power_pins;
			`PSM_IDX_SUSPEND_PINS: next_read = suspend_state_power_pins;
			`PSM_IDX_POLARITY: next_read = polarity;
			`PSM_IDX_DOZE_TIMER: next_read = doze_timer;
			`PSM_IDX_SLEEP_TIMER: next_read = sleep_timer;
			`PSM_IDX_SUSPEND_TIMER: next_read = suspend_timer;
			`PSM_IDX_LCD_SEQ: next_read = {7'h00, lcd_sequence_enable};
			`PSM_IDX_RESUME: next_read = resume_divider;
			`PSM_IDX_ACTIVITY: next_read = {1'b0, activity_status};
			`PSM_IDX_RANGE_LO: next_read = range_lo;
			`PSM_IDX_RANGE_HI: next_read = range_hi;
			default: next_read = 8'h00;
		endcase
	end

	// Bus handshake: one wait cycle, then a single accept cycle.
	always_ff @(posedge clock) begin
		if (reset) begin
			waitrequest <= 1'b1;
			readdata <= 32'h00000000;
		end else if (clock_enable) begin
			waitrequest <= !((read || write) && waitrequest);
			if (read && waitrequest)
				readdata <= {24'h000000, next_read};
		end
	end
endmodule
`default_nettype wire

// file: psm_power_state_manager_chk.sv
// Port assertions for the power state manager.
`timescale 1ns/100ps
`default_nettype none
module psm_power_state_manager_chk (
	// Clock and reset.
	input wire logic clock,
	input wire logic reset,
	// Register bus.
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	// Status and power outputs.
	input wire logic low_battery,
	input wire psm_pkg::psm_pins_t power_pins,
	input wire psm_pkg::psm_clock_t cpu_clock_mode,
	input wire logic oscillator_enable,
	input wire logic io_pins_hiz,
	input wire logic memory_hiz,
	input wire logic refresh_active,
	input wire logic low_battery_irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	wait_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("bus request not answered");
	wait_pulse_a: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low too long");
	read_upper_a: assert property (!waitrequest |-> readdata[31:8] == 24'h0)
		else $error("upper read bits set");
	hiz_osc_a: assert property (io_pins_hiz == !oscillator_enable)
		else $error("pin float and oscillator disagree");
	stop_clock_a: assert property (!oscillator_enable |->
		cpu_clock_mode == psm_pkg::PSM_CLK_STOP) else $error("clock runs");
	suspend_refresh_a: assert property (refresh_active |-> io_pins_hiz && !memory_hiz)
		else $error("refresh outside suspend");
	off_memory_a: assert property (memory_hiz |-> io_pins_hiz && !refresh_active)
		else $error("memory float outside off");
	low_bat_a: assert property (low_battery_irq |-> $past(low_battery))
		else $error("irq without low battery");
	bias_follow_a: assert property (power_pins.lcd_bias_power_pin ==
		power_pins.lcd_power_pin && power_pins.lcd_bias_power_oe ==
		power_pins.lcd_power_oe) else $error("bias differs from lcd");
	lcd_float_a: assert property ($fell(reset) |-> !power_pins.lcd_power_oe)
		else $error("lcd driven after reset");
	oe_sticky_a: assert property (power_pins.lcd_power_oe |=> power_pins.lcd_power_oe)
		else $error("lcd drive dropped");
endmodule
`default_nettype wire

// file: psm_cpu_model.sv
// CPU side model that places I/O cycles on the observed bus.
`timescale 1ns/100ps
`default_nettype none
module psm_cpu_model (
	// Clock.
	input wire logic clock,
	// Observed I/O cycles.
	output var psm_pkg::psm_io_t io_bus
);
	initial io_bus = '0;
	// Idle fields are inverted so a stale address never matches.
	task automatic io(input logic [15:0] a, input logic w, input logic x,
		input logic [7:0] d);
		io_bus <= '{1'b1, w, x, a, d};
		@(posedge clock);
		io_bus <= '{1'b0, 1'b0, 1'b0, ~a, ~d};
		@(posedge clock);
	endtask
endmodule
`default_nettype wire

// file: psm_power_state_manager_tb.sv
// Self-checking testbench for the power state manager.
`timescale 1ns/100ps
`default_nettype none
module psm_power_state_manager_tb;
	localparam int TICKS = 8;
	localparam logic [7:0] rst_val [4] = '{8'hFE, 8'hFF, 8'h0C, 8'h00};
	localparam logic [27:0] acts [15] = '{28'h0378401, 28'h027FC01,
		28'h03BE401, 28'h03BF600, 28'h0060402, 28'h0060E00, 28'h0070C04,
		28'h0071200, 28'h03FFC08, 28'h02F8408, 28'h03F5C10, 28'h01F8410,
		28'h01F0C10, 28'hFFFF420, 28'h1237C40};
	logic clock, reset, read, write, video_access, int_request;
	logic wake_switch_input, modem_ring_wake, low_battery;
	logic dma_request, rtc_alarm;
	logic [9:0] address;
	logic [31:0] writedata, readdata;
	logic waitrequest, oscillator_enable, io_pins_hiz, memory_hiz;
	logic refresh_active, lcd_power_on, low_battery_irq, nmi;
	psm_pkg::psm_io_t io_bus;
	psm_pkg::psm_pins_t power_pins;
	psm_pkg::psm_clock_t cpu_clock_mode;
	logic [7:0] v, p, e;
	logic [15:0] note;
	logic [15:0] notes [$];
	logic [27:0] t;
	integer seed, num_errors, samples_checked;
	wire logic [3:0] pins4 = {power_pins.ram_power_pin,
		power_pins.card_power_pin, power_pins.system_power_pin,
		power_pins.lcd_power_pin};
	wire logic [7:0] sysv = {4'h0, oscillator_enable, io_pins_hiz,
		refresh_active, memory_hiz};
	psm_cpu_model cpu (.clock(clock), .io_bus(io_bus));
	psm_power_state_manager #(.TICK_CYCLES(TICKS)) dut (.clock(clock),
		.reset(reset), .clock_enable(1'b1), .address(address),
		.byteenable(4'hF), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .io_bus(io_bus),
		.video_access(video_access), .int_request(int_request),
		.dma_request(dma_request),
		.wake_switch_input(wake_switch_input),
		.modem_ring_wake(modem_ring_wake), .rtc_alarm(rtc_alarm),
		.low_battery(low_battery), .power_pins(power_pins),
		.cpu_clock_mode(cpu_clock_mode),
		.oscillator_enable(oscillator_enable), .io_pins_hiz(io_pins_hiz),
		.memory_hiz(memory_hiz), .refresh_active(refresh_active),
		.lcd_power_on(lcd_power_on), .low_battery_irq(low_battery_irq),
		.nmi(nmi));
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	task automatic results();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, exp, m);
		samples_checked++;
		if ((got & m) !== (exp & m)) begin
			num_errors++;
			$display("CHECK FAILED %0t read %h want %h", $time, got, exp);
		end
	endtask
	task automatic cmp(input logic [7:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %0t output %h want %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic [7:0] idx, input logic w, input logic [7:0] d);
		address <= {idx, 2'b00};
		read <= !w;
		write <= w;
		writedata <= {24'h0, d};
		@(posedge clock);
		while (waitrequest) @(posedge clock);
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [7:0] idx, exp, m);
		notes.push_back({m, exp});
		bus(idx, 1'b0, 8'h00);
	endtask
	always @(posedge clock) begin
		if (read && !waitrequest && notes.size() > 0) begin
			note = notes.pop_front();
			chk(readdata, {24'h0, note[7:0]}, {24'hFFFFFF, note[15:8]});
		end
	end
	initial begin
		repeat (5000) @(posedge clock);
		num_errors++;
		$display("CHECK FAILED %0t timeout", $time);
		results();
	end
	initial begin
		{seed, num_errors, samples_checked} = {32'd1858, 32'd0, 32'd0};
		{reset, read, write, video_access, int_request} = 5'b10000;
		{wake_switch_input, modem_ring_wake, low_battery} = 3'b000;
		{dma_request, rtc_alarm} = 2'b00;
		address = '0;
		writedata = '0;
		repeat (4) @(posedge clock);
		reset <= 1'b0;
		repeat (3) @(posedge clock);
		cmp({2'b00, power_pins.lcd_power_oe, power_pins.lcd_bias_power_oe, pins4}, 8'h0F);
		for (int i = 0; i < 4; i++) begin
			rd(8'hC6 + 8'(i), rst_val[i], 8'hFF);
		end
		bus(8'hC6, 1'b1, 8'h00);
		rd(8'hC6, 8'hFE, 8'hFF);
		rd(8'h10, 8'h00, 8'hFF);
		rd(8'hC1, 8'h00, 8'h01);
		for (int i = 0; i < 5; i++) begin
			v = 8'($random(seed));
			bus(8'hC6 + 8'(i), 1'b1, v);
			rd(8'hC6 + 8'(i), v, 8'hFF);
		end
		for (int i = 0; i < 4; i++) begin
			p = 8'($random(seed));
			v = 8'($random(seed));
			bus(8'hCA, 1'b1, p);
			bus(8'hC6, 1'b1, v);
			repeat (2) @(posedge clock);
			e = v ^ p;
			cmp({4'h0, pins4}, {4'h0, e[7], e[3], e[2], e[0]});
		end
		bus(8'hCA, 1'b1, 8'h00);
		bus(8'hC6, 1'b1, 8'hFE);
		bus(8'hC8, 1'b1, 8'h0C);
		bus(8'hE0, 1'b1, 8'h30);
		bus(8'hE1, 1'b1, 8'h12);
		foreach (acts[i]) begin
			t = acts[i];
			bus(8'hC0, 1'b1, 8'h01);
			rd(8'hDB, 8'h00, 8'hFF);
			if (t[27:12] == 16'hFFFF) begin
				video_access <= 1'b1;
				@(posedge clock);
				video_access <= 1'b0;
				@(posedge clock);
			end else begin
				cpu.io(t[27:12], t[11], t[10], 8'h00);
			end
			rd(8'hC0, {7'h0, t[9]}, 8'h07);
			rd(8'hDB, t[7:0], 8'hFF);
		end
		bus(8'hC0, 1'b1, 8'h03);
		repeat (2) @(posedge clock);
		cmp(sysv, 8'h06);
		wake_switch_input <= 1'b1;
		repeat (4) @(posedge clock);
		wake_switch_input <= 1'b0;
		cmp(sysv, 8'h08);
		bus(8'hC6, 1'b1, 8'h55);
		rd(8'hC6, 8'hFE, 8'hFF);
		rd(8'hC1, 8'h00, 8'h01);
		bus(8'hC0, 1'b1, 8'h04);
		repeat (2) @(posedge clock);
		cmp(sysv, 8'h05);
		modem_ring_wake <= 1'b1;
		repeat (4) @(posedge clock);
		modem_ring_wake <= 1'b0;
		cmp(sysv, 8'h08);
		rd(8'hC1, 8'h00, 8'h01);
		bus(8'hC0, 1'b1, 8'h03);
		rtc_alarm <= 1'b1;
		repeat (4) @(posedge clock);
		rtc_alarm <= 1'b0;
		cmp(sysv, 8'h08);
		rd(8'hC1, 8'h00, 8'h01);
		low_battery <= 1'b1;
		repeat (3) @(posedge clock);
		cmp({7'h0, low_battery_irq}, 8'h00);
		rd(8'hC1, 8'h01, 8'h01);
		bus(8'hC4, 1'b1, 8'hFE);
		repeat (2) @(posedge clock);
		cmp({7'h0, low_battery_irq}, 8'h01);
		low_battery <= 1'b0;
		bus(8'hC4, 1'b1, 8'hFF);
		bus(8'hD4, 1'b1, 8'h01);
		cmp({6'h0, power_pins.lcd_power_oe, lcd_power_on}, 8'h00);
		cpu.io(16'h03D8, 1'b1, 1'b1, 8'h08);
		repeat (2) @(posedge clock);
		cmp({6'h0, power_pins.lcd_power_oe, lcd_power_on}, 8'h03);
		bus(8'hDA, 1'b1, 8'h05);
		bus(8'hC0, 1'b1, 8'h01);
		repeat (2) @(posedge clock);
		cmp({6'h0, cpu_clock_mode}, {6'h0, psm_pkg::PSM_CLK_DIV4});
		int_request <= 1'b1;
		repeat (2) @(posedge clock);
		cmp({6'h0, cpu_clock_mode}, {6'h0, psm_pkg::PSM_CLK_FULL});
		rd(8'hC0, 8'h01, 8'h07);
		int_request <= 1'b0;
		dma_request <= 1'b1;
		repeat (2) @(posedge clock);
		cmp({6'h0, cpu_clock_mode}, {6'h0, psm_pkg::PSM_CLK_FULL});
		dma_request <= 1'b0;
		repeat (2) @(posedge clock);
		cmp({6'h0, cpu_clock_mode}, {6'h0, psm_pkg::PSM_CLK_DIV4});
		bus(8'hC4, 1'b1, 8'hFD);
		wake_switch_input <= 1'b1;
		repeat (3) @(posedge clock);
		wake_switch_input <= 1'b0;
		cmp({7'h0, nmi}, 8'h01);
		rd(8'hC0, 8'h40, 8'h70);
		rd(8'hC4, 8'hFD, 8'hFF);
		bus(8'hC4, 1'b1, 8'hFF);
		repeat (2) @(posedge clock);
		cmp({7'h0, nmi}, 8'h00);
		bus(8'hCD, 1'b1, 8'h01);
		bus(8'hCC, 1'b1, 8'h01);
		bus(8'hC0, 1'b1, 8'h00);
		repeat (5 * TICKS) @(posedge clock);
		rd(8'hC0, 8'h02, 8'h07);
		cmp({4'h0, pins4}, 8'h06);
		results();
	end
endmodule
bind psm_power_state_manager psm_power_state_manager_chk chk (
	.clock(clock), .reset(reset), .read(read), .write(write),
	.readdata(readdata), .waitrequest(waitrequest),
	.low_battery(low_battery), .power_pins(power_pins),
	.cpu_clock_mode(cpu_clock_mode), .oscillator_enable(oscillator_enable),
	.io_pins_hiz(io_pins_hiz), .memory_hiz(memory_hiz),
	.refresh_active(refresh_active), .low_battery_irq(low_battery_irq));
`default_nettype wire
